// [verilog/auip_slave.sv]
// Purpose: AXI5 memory slave echoing unique-id flags and sampling partition info
// Assumes: master and bus logic on the same clock; single-beat B per write
// Notes: reads are served one at a time, so read data is never interleaved
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module auip_slave #(
  parameter bit INTERLEAVE_DISABLED = 1'b1,
  parameter bit UNIQUE_ID_SUPPORT   = 1'b1,
  parameter bit MPAM_SUPPORT        = 1'b1
) (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         ar_valid,
  input  wire auip_pkg::auip_areq_t         ar_req,
  output logic                              ar_ready,
  output logic                              r_valid,
  output auip_pkg::auip_rbeat_t             r_beat,
  input  wire logic                         r_ready,
  input  wire logic                         aw_valid,
  input  wire auip_pkg::auip_areq_t         aw_req,
  output logic                              aw_ready,
  input  wire logic                         w_valid,
  input  wire logic [auip_pkg::DATA_W-1:0]  w_data,
  input  wire logic [auip_pkg::DATA_W/8-1:0] w_strb,
  input  wire logic                         w_last,
  output logic                              w_ready,
  output logic                              b_valid,
  output auip_pkg::auip_bresp_t             b_resp,
  input  wire logic                         b_ready,
  input  wire logic [auip_pkg::LITE_AW-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [auip_pkg::LITE_AW-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  typedef enum logic [0:0] {
    RD_IDLE,
    RD_DATA
  } auip_rd_st_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_DATA,
    WR_RESP
  } auip_wr_st_t;

  localparam int DEPTH = 1 << auip_pkg::MEM_AW;

  logic [auip_pkg::DATA_W-1:0]  mem [DEPTH];
  auip_rd_st_t                  rd_st_ff;
  auip_wr_st_t                  wr_st_ff;
  logic [auip_pkg::LEN_W-1:0]   rd_len_ff;
  logic [auip_pkg::LEN_W-1:0]   rd_cnt_ff;
  logic [auip_pkg::MEM_AW-1:0]  rd_idx_ff;
  logic [auip_pkg::MEM_AW-1:0]  wr_idx_ff;
  logic [auip_pkg::MEM_AW-1:0]  nxt_rd_idx;
  logic [auip_pkg::MPAM_W-1:0]  rd_mpam_ff;
  logic [auip_pkg::MPAM_W-1:0]  wr_mpam_ff;
  logic [31:0]                  ctrl_ff;
  logic [auip_pkg::CNT_W-1:0]   rd_unq_cnt_ff;
  logic [auip_pkg::CNT_W-1:0]   wr_unq_cnt_ff;
  logic                         ar_take;
  logic                         aw_take;
  logic                         r_take;
  logic                         w_take;
  logic                         use_dflt;
  logic                         lite_wr_en;
  logic [auip_pkg::LITE_AW-1:0] lite_wr_addr;
  logic [31:0]                  lite_wr_data;
  logic [3:0]                   lite_wr_strb;
  logic                         lite_wr_ok;
  logic [31:0]                  lite_rd_data;
  logic                         lite_rd_ok;

  // gives the 11-bit partition field, or the system default for a master without one
  function automatic logic [auip_pkg::MPAM_W-1:0] mpam_resolve(
    input logic [auip_pkg::MPAM_W-1:0] mpam,
    input logic [2:0]                  prot,
    input logic                        dflt
  );
    logic [auip_pkg::MPAM_W-1:0] res;
    res = mpam;
    if (dflt) begin
      res[auip_pkg::NS_BIT] = prot[auip_pkg::PROT_NS];
      res[auip_pkg::PARTID_MSB:auip_pkg::PARTID_LSB] = auip_pkg::PARTID_DFLT;
      res[auip_pkg::PMG_BIT] = auip_pkg::PMG_DFLT;
    end
    return res;
  endfunction

  function automatic logic [auip_pkg::MEM_AW-1:0] word_idx(
    input logic [auip_pkg::ADDR_W-1:0] addr
  );
    return addr[auip_pkg::MEM_LSB +: auip_pkg::MEM_AW];
  endfunction

  assign ar_take  = ar_valid & ar_ready;
  assign aw_take  = aw_valid & aw_ready;
  assign r_take   = r_valid & r_ready;
  assign w_take   = w_valid & w_ready;
  // no partition support: field forced to defaults and unused
  assign use_dflt = ctrl_ff[auip_pkg::CTRL_DFLT_BIT] | ~MPAM_SUPPORT;
  assign nxt_rd_idx = rd_idx_ff + 1'b1;

  // one read at a time, never interleaved
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_st_ff  <= RD_IDLE;
      ar_ready  <= 1'b1;
      r_valid   <= 1'b0;
      r_beat    <= '0;
      rd_len_ff <= '0;
      rd_cnt_ff <= '0;
      rd_idx_ff <= '0;
    end else begin
      case (rd_st_ff)
        RD_IDLE: begin
          if (ar_take) begin
            rd_st_ff     <= RD_DATA;
            ar_ready     <= 1'b0;
            r_valid      <= 1'b1;
            rd_len_ff    <= ar_req.len;
            rd_cnt_ff    <= '0;
            rd_idx_ff    <= word_idx(ar_req.addr);
            r_beat.id    <= ar_req.id;
            r_beat.data  <= mem[word_idx(ar_req.addr)];
            r_beat.resp  <= auip_pkg::RESP_OKAY;
            r_beat.last  <= (ar_req.len == '0);
            r_beat.idunq <= ar_req.idunq & UNIQUE_ID_SUPPORT;
          end
        end
        RD_DATA: begin
          if (r_take) begin
            if (r_beat.last) begin
              // read no longer outstanding after final beat accepted
              rd_st_ff <= RD_IDLE;
              ar_ready <= 1'b1;
              r_valid  <= 1'b0;
            end else begin
              rd_cnt_ff   <= rd_cnt_ff + 1'b1;
              rd_idx_ff   <= nxt_rd_idx;
              r_beat.data <= mem[nxt_rd_idx];
              r_beat.last <= (rd_cnt_ff + 1'b1 == rd_len_ff);
            end
          end
        end
        default: begin
          rd_st_ff <= RD_IDLE;
          ar_ready <= 1'b1;
          r_valid  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_st_ff  <= WR_IDLE;
      aw_ready  <= 1'b1;
      w_ready   <= 1'b0;
      b_valid   <= 1'b0;
      b_resp    <= '0;
      wr_idx_ff <= '0;
    end else begin
      case (wr_st_ff)
        WR_IDLE: begin
          if (aw_take) begin
            wr_st_ff     <= WR_DATA;
            aw_ready     <= 1'b0;
            w_ready      <= 1'b1;
            wr_idx_ff    <= word_idx(aw_req.addr);
            b_resp.id    <= aw_req.id;
            b_resp.resp  <= auip_pkg::RESP_OKAY;
            b_resp.idunq <= aw_req.idunq & UNIQUE_ID_SUPPORT;
            b_resp.comp  <= 1'b1;
          end
        end
        WR_DATA: begin
          if (w_take) begin
            wr_idx_ff <= wr_idx_ff + 1'b1;
            if (w_last) begin
              wr_st_ff <= WR_RESP;
              w_ready  <= 1'b0;
              b_valid  <= 1'b1;
            end
          end
        end
        WR_RESP: begin
          if (b_ready) begin
            // write ends with its accepted response; no atomics
            wr_st_ff <= WR_IDLE;
            b_valid  <= 1'b0;
            aw_ready <= 1'b1;
          end
        end
        default: begin
          wr_st_ff <= WR_IDLE;
          aw_ready <= 1'b1;
          w_ready  <= 1'b0;
          b_valid  <= 1'b0;
        end
      endcase
    end
  end

  // data memory has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (w_take) begin
      for (int i = 0; i < auip_pkg::DATA_W / 8; i++) begin
        if (w_strb[i]) begin
          mem[wr_idx_ff][i*8 +: 8] <= w_data[i*8 +: 8];
        end
      end
    end
  end

  // 11-bit field sampled on the address handshake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_mpam_ff <= '0;
      wr_mpam_ff <= '0;
    end else begin
      // dvm reads leave the captured field alone
      if (ar_take && !ar_req.dvm) begin
        rd_mpam_ff <= mpam_resolve(ar_req.mpam, ar_req.prot, use_dflt);
      end
      if (aw_take) begin
        wr_mpam_ff <= mpam_resolve(aw_req.mpam, aw_req.prot, use_dflt);
      end
    end
  end

  // unique flags counted only when supported
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_unq_cnt_ff <= '0;
      wr_unq_cnt_ff <= '0;
    end else begin
      if (ar_take && ar_req.idunq && UNIQUE_ID_SUPPORT) begin
        rd_unq_cnt_ff <= rd_unq_cnt_ff + 1'b1;
      end
      if (aw_take && aw_req.idunq && UNIQUE_ID_SUPPORT) begin
        wr_unq_cnt_ff <= wr_unq_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= auip_pkg::CTRL_RST;
    end else if (lite_wr_en && lite_wr_addr == auip_pkg::REG_CTRL && lite_wr_strb[0]) begin
      ctrl_ff[auip_pkg::CTRL_DFLT_BIT] <= lite_wr_data[auip_pkg::CTRL_DFLT_BIT];
    end
  end

  // writes to read-only registers are answered OKAY and dropped
  always_comb begin
    case (lite_wr_addr)
      auip_pkg::REG_CTRL, auip_pkg::REG_STATUS, auip_pkg::REG_RD_MPAM,
      auip_pkg::REG_WR_MPAM, auip_pkg::REG_UNQ_CNT, auip_pkg::REG_PROPS: lite_wr_ok = 1'b1;
      default: lite_wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    lite_rd_ok   = 1'b1;
    lite_rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      auip_pkg::REG_CTRL:    lite_rd_data = ctrl_ff;
      auip_pkg::REG_STATUS:  lite_rd_data = {30'h0, wr_st_ff != WR_IDLE, rd_st_ff != RD_IDLE};
      auip_pkg::REG_RD_MPAM: lite_rd_data = {21'h0, rd_mpam_ff};
      auip_pkg::REG_WR_MPAM: lite_rd_data = {21'h0, wr_mpam_ff};
      auip_pkg::REG_UNQ_CNT: lite_rd_data = {wr_unq_cnt_ff, rd_unq_cnt_ff};
      auip_pkg::REG_PROPS:   lite_rd_data = {29'h0, MPAM_SUPPORT, UNIQUE_ID_SUPPORT,
                                             INTERLEAVE_DISABLED};
      default:               lite_rd_ok   = 1'b0;
    endcase
  end

  auip_lite_slave u_lite (
    .clk,
    .arst_n,
    .s_axi_awaddr,
    .s_axi_awvalid,
    .s_axi_awready,
    .s_axi_wdata,
    .s_axi_wstrb,
    .s_axi_wvalid,
    .s_axi_wready,
    .s_axi_bresp,
    .s_axi_bvalid,
    .s_axi_bready,
    .s_axi_araddr,
    .s_axi_arvalid,
    .s_axi_arready,
    .s_axi_rdata,
    .s_axi_rresp,
    .s_axi_rvalid,
    .s_axi_rready,
    .wr_en         (lite_wr_en),
    .wr_addr       (lite_wr_addr),
    .wr_data       (lite_wr_data),
    .wr_strb       (lite_wr_strb),
    .wr_ok         (lite_wr_ok),
    .rd_data       (lite_rd_data),
    .rd_ok         (lite_rd_ok)
  );
endmodule

// [shared/auip_pkg.sv]
// Purpose: constants and carrier types for the unique-id / partition-info AXI5 slave
// Assumes: one clock, asynchronous active-low reset
// Notes: Contract list below; register offsets are byte addresses on the AXI4-Lite port
// Contract
// - interleave-disabled master needs a slave that is also interleave-disabled
// - interleave-disabled slave never mixes read beats of different transactions
// - interleaving slave pairs only with interleaving master; undeclared means false
// - every read beat echoes the request's read unique flag
// - every write response echoes the request's write unique flag
// - outstanding lasts from address valid until final response accepted
// - with a completion flag, write outstanding until response carries it
// - atomic outstanding until both write and read responses accepted
// - unique support true means flags on all four channels, else absent; here the flags stay, ignored on AR/AW and driven low on R/B
// - partition support gives an 11-bit field on each address channel
// - field packs security bit 0, partition id 9:1, monitor group 10
// - missing master field defaults: security from prot bit 1, zeros elsewhere
// - field driven and sampled whenever address valid is high
// - receiver ignores the read partition field on dvm operations
// - without partition support no partition signals exist; here the mpam fields stay in the requests and resolve to defaults
package auip_pkg;
  localparam int ID_W       = 4;
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int LEN_W      = 8;
  localparam int MPAM_W     = 11;
  localparam int PARTID_W   = 9;
  localparam int NS_BIT     = 0;
  localparam int PARTID_LSB = 1;
  localparam int PARTID_MSB = 9;
  localparam int PMG_BIT    = 10;
  localparam int PROT_NS    = 1;
  localparam logic [PARTID_W-1:0] PARTID_DFLT = 9'h000;
  localparam logic                PMG_DFLT    = 1'h0;
  localparam int MEM_AW     = 4;
  localparam int MEM_LSB    = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int LITE_AW    = 8;
  localparam logic [LITE_AW-1:0] REG_CTRL    = 8'h00;
  localparam logic [LITE_AW-1:0] REG_STATUS  = 8'h04;
  localparam logic [LITE_AW-1:0] REG_RD_MPAM = 8'h08;
  localparam logic [LITE_AW-1:0] REG_WR_MPAM = 8'h0C;
  localparam logic [LITE_AW-1:0] REG_UNQ_CNT = 8'h10;
  localparam logic [LITE_AW-1:0] REG_PROPS   = 8'h14;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_DFLT_BIT = 0;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
    logic [2:0]        prot;
    logic              idunq;
    logic [MPAM_W-1:0] mpam;
    logic              dvm;
  } auip_areq_t;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [DATA_W-1:0] data;
    logic [1:0]        resp;
    logic              last;
    logic              idunq;
  } auip_rbeat_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [1:0]      resp;
    logic            idunq;
    logic            comp;
  } auip_bresp_t;
endpackage

// [verilog/auip_lite_slave.sv]
// Purpose: AXI4-Lite register port, one write and one read in flight
// Assumes: register decode is combinational in the parent
// Notes: read data one cycle after address accept; write strobe one cycle before bvalid
`timescale 1ns/1ps
module auip_lite_slave (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic [auip_pkg::LITE_AW-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [auip_pkg::LITE_AW-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic                              wr_en,
  output logic [auip_pkg::LITE_AW-1:0]      wr_addr,
  output logic [31:0]                       wr_data,
  output logic [3:0]                        wr_strb,
  input  wire logic                         wr_ok,
  input  wire logic [31:0]                  rd_data,
  input  wire logic                         rd_ok
);
  logic have_aw_ff;
  logic have_w_ff;

  assign s_axi_awready = ~have_aw_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~have_w_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_en         = have_aw_ff & have_w_ff & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
      wr_addr    <= '0;
      wr_data    <= 32'h0000_0000;
      wr_strb    <= 4'h0;
    end else if (wr_en) begin
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_ff <= 1'b1;
        wr_addr    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_ff <= 1'b1;
        wr_data   <= s_axi_wdata;
        wr_strb   <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= auip_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? auip_pkg::RESP_OKAY : auip_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= auip_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? auip_pkg::RESP_OKAY : auip_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [sim/auip_slave_sva.sv]
// Purpose: checks on the AXI5 side of the slave
// Assumes: one clock, asynchronous active-low reset
// Notes: echoes compared with the request captured at its address take
`timescale 1ns/1ps
module auip_slave_sva #(
  parameter bit UNIQUE_ID_SUPPORT = 1'h1
) (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  ar_valid,
  input wire auip_pkg::auip_areq_t  ar_req,
  input wire logic                  ar_ready,
  input wire logic                  r_valid,
  input wire auip_pkg::auip_rbeat_t r_beat,
  input wire logic                  r_ready,
  input wire logic                  aw_valid,
  input wire auip_pkg::auip_areq_t  aw_req,
  input wire logic                  aw_ready,
  input wire logic                  b_valid,
  input wire auip_pkg::auip_bresp_t b_resp,
  input wire logic                  b_ready
);
  logic [auip_pkg::ID_W-1:0] rid_ff;
  logic                      runq_ff;
  logic                      wunq_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rid_ff  <= '0;
      runq_ff <= 1'h0;
    end else if (ar_valid && ar_ready) begin
      rid_ff  <= ar_req.id;
      runq_ff <= ar_req.idunq & UNIQUE_ID_SUPPORT;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wunq_ff <= 1'h0;
    end else if (aw_valid && aw_ready) begin
      wunq_ff <= aw_req.idunq & UNIQUE_ID_SUPPORT;
    end
  end
  rd_no_mix_a: assert property (r_valid && !(r_ready && r_beat.last) |=> r_valid && $stable(r_beat.id))
    else $error("read burst interleaved");
  rd_id_echo_a: assert property (r_valid |-> r_beat.id == rid_ff)
    else $error("read id not echoed");
  rd_unq_echo_a: assert property (r_valid |-> r_beat.idunq == runq_ff)
    else $error("read unique flag not echoed");
  rd_single_a: assert property (ar_valid && ar_ready |=> !ar_ready && r_valid)
    else $error("read taken during burst");
  rd_close_a: assert property (r_valid && r_ready && r_beat.last |=> !r_valid && ar_ready)
    else $error("read not closed");
  wr_unq_echo_a: assert property (b_valid |-> b_resp.idunq == wunq_ff)
    else $error("write unique flag not echoed");
  wr_comp_a: assert property (b_valid |-> b_resp.comp)
    else $error("response without completion");
  b_hold_a: assert property (b_valid && !b_ready |=> b_valid && $stable(b_resp))
    else $error("response dropped");
  wr_busy_a: assert property (aw_valid && aw_ready |=> !aw_ready [*2])
    else $error("write address reopened too early");
  rd_unq_c: cover property (r_valid && r_ready && r_beat.last && r_beat.idunq);
  wr_unq_c: cover property (b_valid && b_ready && b_resp.idunq);
  rd_stall_c: cover property (r_valid && !r_ready);
endmodule
bind auip_slave auip_slave_sva #(.UNIQUE_ID_SUPPORT(UNIQUE_ID_SUPPORT)) auip_slave_sva_inst (.*);

// [sim/auip_mst_model.sv]
// Purpose: behavioural AXI5 requester facing the slave
// Assumes: one request per direction in flight
// Notes: released payload shows its inverse so stale values are not mistaken for live ones
`timescale 1ns/1ps
module auip_mst_model (
  input  wire logic                  clk,
  output logic                       ar_valid,
  output auip_pkg::auip_areq_t       ar_req,
  input  wire logic                  ar_ready,
  input  wire logic                  r_valid,
  input  wire auip_pkg::auip_rbeat_t r_beat,
  output logic                       r_ready,
  output logic                       aw_valid,
  output auip_pkg::auip_areq_t       aw_req,
  input  wire logic                  aw_ready,
  output logic                       w_valid,
  output logic [31:0]                w_data,
  output logic [3:0]                 w_strb,
  output logic                       w_last,
  input  wire logic                  w_ready,
  input  wire logic                  b_valid,
  input  wire auip_pkg::auip_bresp_t b_resp,
  output logic                       b_ready
);
  auip_pkg::auip_rbeat_t rq[$];
  int                    slow = 0;
  initial begin
    {ar_valid, r_ready, aw_valid, w_valid, w_last, b_ready} = 6'h00;
    ar_req = '0;
    aw_req = '0;
    w_data = 32'h0000_0000;
    w_strb = 4'hF;
  end
  // flag and field held with valid
  task automatic rd(input auip_pkg::auip_areq_t q);
    rq.delete();
    ar_req   <= q;
    ar_valid <= 1'h1;
    do @(posedge clk); while (!ar_ready);
    ar_valid <= 1'h0;
    ar_req   <= ~q;
    repeat (slow) @(posedge clk);
    r_ready <= 1'h1;
    do begin
      @(posedge clk);
      if (r_valid) rq.push_back(r_beat);
    end while (!(r_valid && r_beat.last));
    r_ready <= 1'h0;
  endtask
  // write held until its completing response
  task automatic wr(input auip_pkg::auip_areq_t q, input int n, input logic [31:0] d,
                    output auip_pkg::auip_bresp_t bl);
    aw_req   <= q;
    aw_valid <= 1'h1;
    do @(posedge clk); while (!aw_ready);
    aw_valid <= 1'h0;
    aw_req   <= ~q;
    for (int i = 0; i < n; i++) begin
      w_valid <= 1'h1;
      w_data  <= d + 32'(i);
      w_last  <= (i == n - 1);
      do @(posedge clk); while (!w_ready);
    end
    {w_valid, w_last} <= 2'h0;
    w_data  <= ~w_data;
    repeat (slow) @(posedge clk);
    b_ready <= 1'h1;
    do @(posedge clk); while (!b_valid);
    bl = b_resp;
    b_ready <= 1'h0;
  endtask
endmodule

// [sim/auip_slave_tb_top.sv]
// Purpose: directed bench for the unique-id / partition-field slave
// Assumes: default parameters, all features enabled
// Notes: AXI4-Lite port driven here, AXI5 side by the requester model
`timescale 1ns/1ps
module auip_slave_tb_top;
  logic                  clk;
  logic                  arst_n;
  logic                  ar_valid, ar_ready, r_valid, r_ready, aw_valid, aw_ready;
  logic                  w_valid, w_last, w_ready, b_valid, b_ready;
  logic [31:0]           w_data, s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]            w_strb, s_axi_wstrb;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rd_r;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  auip_pkg::auip_areq_t  ar_req, aw_req, q;
  auip_pkg::auip_rbeat_t r_beat;
  auip_pkg::auip_bresp_t b_resp, bl;
  int                    miscompares = 0, checks_done = 0, cyc = 0;

  auip_slave auip_slave_inst (.*);
  auip_mst_model auip_mst_model_inst (.*);

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic lite_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rd_r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic lite_rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    lite_rd(a);
    chk(n, e, rd_v);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    arst_n = 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    rchk(auip_pkg::REG_PROPS, 32'h0000_0007, "props");
    rchk(auip_pkg::REG_CTRL, 32'h0000_0000, "ctrl reset");
    rchk(auip_pkg::REG_STATUS, 32'h0000_0000, "status idle");
    lite_wr(auip_pkg::REG_PROPS, 32'h0000_0000);
    chk("ro write resp", 32'h0000_0000, {30'h0, rd_r});
    rchk(auip_pkg::REG_PROPS, 32'h0000_0007, "props read only");
    lite_rd(8'h18);
    chk("unmapped resp", 32'h0000_0002, {30'h0, rd_r});
    $display("test registers done");
    q = '0;
    q.id = 4'h5;
    q.idunq = 1'h1;
    q.mpam = 11'h5A3;
    auip_mst_model_inst.slow = 2;
    auip_mst_model_inst.wr(q, 2, 32'hA000_0000, bl);
    chk("b id resp", {26'h0, 4'h5, auip_pkg::RESP_OKAY}, {26'h0, bl.id, bl.resp});
    chk("b unique", 32'h0000_0001, {31'h0, bl.idunq});
    chk("b comp", 32'h0000_0001, {31'h0, bl.comp});
    rchk(auip_pkg::REG_WR_MPAM, 32'h0000_05A3, "write field");
    q.id = 4'h6;
    q.idunq = 1'h0;
    q.addr = 32'h0000_0008;
    auip_mst_model_inst.wr(q, 1, 32'hB000_0000, bl);
    chk("b not unique", 32'h0000_0000, {31'h0, bl.idunq});
    $display("test writes done");
    q = '0;
    q.id = 4'h3;
    q.idunq = 1'h1;
    q.len = 8'h01;
    q.mpam = 11'h7FE;
    auip_mst_model_inst.rd(q);
    for (int i = 0; i < 2; i++) begin
      chk("r data", 32'hA000_0000 + 32'(i), auip_mst_model_inst.rq[i].data);
      chk("r id resp unique last", {24'h0, 4'h3, auip_pkg::RESP_OKAY, 1'h1, i == 1},
        {24'h0, auip_mst_model_inst.rq[i].id, auip_mst_model_inst.rq[i].resp,
        auip_mst_model_inst.rq[i].idunq, auip_mst_model_inst.rq[i].last});
    end
    q.idunq = 1'h0;
    q.len = 8'h00;
    q.addr = 32'h0000_0008;
    q.mpam = 11'h155;
    auip_mst_model_inst.slow = 0;
    auip_mst_model_inst.rd(q);
    chk("r data single", 32'hB000_0000, auip_mst_model_inst.rq[0].data);
    chk("r not unique", 32'h0000_0000, {31'h0, auip_mst_model_inst.rq[0].idunq});
    rchk(auip_pkg::REG_RD_MPAM, 32'h0000_0155, "read field");
    rchk(auip_pkg::REG_UNQ_CNT, 32'h0001_0001, "unique counts");
    q.dvm = 1'h1;
    q.mpam = 11'h0FF;
    auip_mst_model_inst.rd(q);
    rchk(auip_pkg::REG_RD_MPAM, 32'h0000_0155, "dvm field ignored");
    $display("test reads done");
    lite_wr(auip_pkg::REG_CTRL, 32'h0000_0001);
    rchk(auip_pkg::REG_CTRL, 32'h0000_0001, "ctrl written");
    q.dvm = 1'h0;
    q.prot = 3'h2;
    q.mpam = 11'h7FF;
    auip_mst_model_inst.rd(q);
    rchk(auip_pkg::REG_RD_MPAM, 32'h0000_0001, "default secure set");
    q.prot = 3'h5;
    auip_mst_model_inst.rd(q);
    rchk(auip_pkg::REG_RD_MPAM, 32'h0000_0000, "default secure clear");
    $display("test defaults done");
    final_report();
  end
endmodule
